/* pps_map.svh */
`ifndef PPS_MAP_SVH
`define PPS_MAP_SVH
// operating modes
`define PPS_MODE_EXP1    2'h1
`define PPS_MODE_EXP2    2'h2
`define PPS_MODE_SINGLE  2'h3
// bit positions inside port 7
`define PPS_P7_RD_BIT    4
`define PPS_P7_WR_BIT    5
`define PPS_P7_AS_BIT    6
`define PPS_P7_WAIT_BIT  7
// bit position of the shared clock pin in port 4
`define PPS_P4_CLK_BIT   6
`endif

/* pps_pkg.sv */
package pps_pkg;
    typedef enum logic [2:0] {
        PPS_COND_RESET,
        PPS_COND_HWSTBY,
        PPS_COND_SWSTBY,
        PPS_COND_SLEEP,
        PPS_COND_NORMAL
    } pps_cond_e;

    typedef struct packed {
        logic [7:0] addrLo;
        logic [7:0] addrHi;
        logic [7:0] p1Out;
        logic [7:0] p2Out;
        logic [7:0] p3Out;
        logic [7:0] p4Out;
        logic [7:0] p5Out;
        logic [7:0] p6Out;
        logic [7:0] p7Out;
        logic [7:0] p1Oe;
        logic [7:0] p2Oe;
        logic [7:0] p3Oe;
        logic [7:0] p4Oe;
        logic [7:0] p5Oe;
        logic [7:0] p6Oe;
        logic [7:0] p7Oe;
    } pps_state_s;
endpackage : pps_pkg

/* pps_port_pin_state.sv */
`include "pps_map.svh"

module pps_port_pin_state
    import pps_pkg::*;
#(
    parameter int NPORT = 7
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    // operating condition and mode
    input  wire pps_cond_e  opCond,
    input  wire logic [1:0] mcuMode,
    // port direction and value bits, ports 1..7 packed low to high
    input  wire logic [NPORT*8-1:0] portDir,
    input  wire logic [NPORT*8-1:0] pin_output_value_bit,
    // peripheral overrides per pin
    input  wire logic [NPORT*8-1:0] periphEn,
    input  wire logic [NPORT*8-1:0] periphOe,
    input  wire logic [NPORT*8-1:0] periphOut,
    // external bus from the cpu core
    input  wire logic [15:0] busAddr,
    input  wire logic [7:0]  busWrData,
    input  wire logic        busWrEn,
    input  wire logic        addr_strobe_pin,
    input  wire logic        busWrStrobe,
    input  wire logic        busRdStrobe,
    input  wire logic        sysClkOut,
    // pins
    output logic [NPORT*8-1:0] pinOut,
    output logic [NPORT*8-1:0] pinOe,
    output logic [NPORT*8-1:0] pinPullUp,
    output logic               peripheralReset
);
    logic       rstMeta;
    logic       rstSync_n;
    pps_state_s st_r;
    pps_state_s st_nxt;
    logic [NPORT*8-1:0] outQ;
    logic [NPORT*8-1:0] oeQ;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta   <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstMeta   <= 1'b1;
            rstSync_n <= rstMeta;
        end
    end

    function automatic logic isExpanded(input logic [1:0] m);
        isExpanded = (m == `PPS_MODE_EXP1) || (m == `PPS_MODE_EXP2);
    endfunction : isExpanded

    assign outQ = {st_r.p7Out, st_r.p6Out, st_r.p5Out, st_r.p4Out,
                   st_r.p3Out, st_r.p2Out, st_r.p1Out};
    assign oeQ  = {st_r.p7Oe, st_r.p6Oe, st_r.p5Oe, st_r.p4Oe,
                   st_r.p3Oe, st_r.p2Oe, st_r.p1Oe};

    // peripherals are held in reset while in software standby
    assign peripheralReset = (opCond == PPS_COND_SWSTBY) ||
                             (opCond == PPS_COND_RESET);

    always_comb begin
        logic [NPORT*8-1:0] o;
        logic [NPORT*8-1:0] e;
        logic [NPORT*8-1:0] pu;
        logic               exp;
        int                 ck;
        o   = outQ;
        e   = oeQ;
        pu  = '0;
        exp = isExpanded(mcuMode);
        ck  = 24 + `PPS_P4_CLK_BIT;
        st_nxt = st_r;
        unique case (opCond)
            PPS_COND_RESET: begin
                o = '0;
                e = '0;
                if (exp) begin
                    // mode 2 address pins float until directions are set
                    if (mcuMode == `PPS_MODE_EXP1) begin
                        e[15:0] = 16'hFFFF;
                    end
                    o[15:0] = 16'h0000;
                    e[ck] = 1'b1;
                    o[ck] = sysClkOut;
                    for (int i = `PPS_P7_RD_BIT; i <= `PPS_P7_AS_BIT; i++) begin
                        e[48+i] = 1'b1;
                        o[48+i] = 1'b1;
                    end
                end
            end
            PPS_COND_HWSTBY: begin
                o = '0;
                e = '0;
            end
            PPS_COND_SWSTBY: begin
                // plain port per direction and value bits
                for (int i = 0; i < NPORT*8; i++) begin
                    e[i] = portDir[i];
                    o[i] = pin_output_value_bit[i];
                end
                if (exp) begin
                    if (mcuMode == `PPS_MODE_EXP1) begin
                        e[15:0] = 16'hFFFF;
                        o[15:0] = 16'h0000;
                    end else begin
                        for (int i = 0; i < 16; i++)
                            if (portDir[i]) o[i] = 1'b0;
                    end
                    e[23:16] = 8'h00;
                    e[ck] = 1'b1;
                    o[ck] = 1'b1;
                    for (int i = `PPS_P7_RD_BIT; i <= `PPS_P7_AS_BIT; i++) begin
                        e[48+i] = 1'b1;
                        o[48+i] = 1'b1;
                    end
                    e[48+`PPS_P7_WAIT_BIT] = 1'b0;
                end else begin
                    e[ck] = portDir[ck];
                    o[ck] = 1'b1;
                end
            end
            PPS_COND_SLEEP: begin
                // everything else keeps its previous state
                if (exp) begin
                    for (int i = 0; i < 8; i++) begin
                        o[i]   = st_r.addrLo[i];
                        o[8+i] = st_r.addrHi[i];
                    end
                    e[23:16] = 8'h00;
                    e[ck] = 1'b1;
                    o[ck] = sysClkOut;
                    for (int i = `PPS_P7_RD_BIT; i <= `PPS_P7_AS_BIT; i++) begin
                        e[48+i] = 1'b1;
                        o[48+i] = 1'b1;
                    end
                end else begin
                    e[ck] = portDir[ck];
                    o[ck] = sysClkOut;
                end
            end
            PPS_COND_NORMAL: begin
                for (int i = 0; i < NPORT*8; i++) begin
                    if (periphEn[i]) begin
                        e[i] = periphOe[i];
                        o[i] = periphOut[i];
                    end else begin
                        e[i] = portDir[i];
                        o[i] = pin_output_value_bit[i];
                    end
                end
                if (exp) begin
                    for (int i = 0; i < 16; i++) begin
                        e[i] = (mcuMode == `PPS_MODE_EXP1) || portDir[i];
                        o[i] = busAddr[i];
                    end
                    e[23:16] = {8{busWrEn}};
                    o[23:16] = busWrData;
                    e[ck] = 1'b1;
                    o[ck] = sysClkOut;
                    e[48+`PPS_P7_AS_BIT] = 1'b1;
                    o[48+`PPS_P7_AS_BIT] = addr_strobe_pin;
                    e[48+`PPS_P7_WR_BIT] = 1'b1;
                    o[48+`PPS_P7_WR_BIT] = busWrStrobe;
                    e[48+`PPS_P7_RD_BIT] = 1'b1;
                    o[48+`PPS_P7_RD_BIT] = busRdStrobe;
                    st_nxt.addrLo = busAddr[7:0];
                    st_nxt.addrHi = busAddr[15:8];
                end else begin
                    e[ck] = portDir[ck];
                    o[ck] = sysClkOut;
                end
            end
            default: begin
                o = '0;
                e = '0;
            end
        endcase
        // held or plain inputs: pull-up only for direction 0, value 1
        for (int i = 0; i < NPORT*8; i++)
            pu[i] = !e[i] && !portDir[i] && pin_output_value_bit[i] &&
                    (opCond != PPS_COND_HWSTBY) &&
                    (opCond != PPS_COND_RESET);
        // held outputs keep their last level through the state copy
        {st_nxt.p7Out, st_nxt.p6Out, st_nxt.p5Out, st_nxt.p4Out,
         st_nxt.p3Out, st_nxt.p2Out, st_nxt.p1Out} = o;
        {st_nxt.p7Oe, st_nxt.p6Oe, st_nxt.p5Oe, st_nxt.p4Oe,
         st_nxt.p3Oe, st_nxt.p2Oe, st_nxt.p1Oe} = e;
        pinPullUp = pu;
    end

    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // clock pin is gated by its enable flop and passes the live clock except in software standby, where it comes from its flop; other pins come from flops
    always_comb begin
        pinOut = outQ;
        pinOe  = oeQ;
        pinOut[24+`PPS_P4_CLK_BIT] = oeQ[24+`PPS_P4_CLK_BIT] &&
            ((opCond == PPS_COND_SWSTBY) ? outQ[24+`PPS_P4_CLK_BIT]
                                         : sysClkOut);
    end
endmodule : pps_port_pin_state

/* pps_port_pin_state_asserts.sv */
module pps_port_pin_state_asserts
    import pps_pkg::*;
#(parameter int NPORT = 7) (
    // clock, reset and controls
    input wire logic                 clk_sys, reset_n,
    input wire pps_cond_e            opCond,
    input wire logic [1:0]           mcuMode,
    input wire logic [NPORT*8-1:0]   portDir, pin_output_value_bit,
    input wire logic [NPORT*8-1:0]   periphEn, periphOe, periphOut,
    input wire logic [15:0]          busAddr,
    input wire logic [7:0]           busWrData,
    input wire logic                 busWrEn, addr_strobe_pin, busWrStrobe,
    input wire logic                 busRdStrobe, sysClkOut, peripheralReset,
    // pins
    input wire logic [NPORT*8-1:0]   pinOut, pinOe, pinPullUp
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] live_r;
    // pins stay quiet just after release, so checks wait it out
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) live_r <= '0;
        else live_r <= {live_r[2:0], 1'b1};
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_hwstby_float: assert property (live_r[3] &&
        opCond == PPS_COND_HWSTBY |=> pinOe == '0) else $error("hw drive");
    a_pullup_gate: assert property ((pinPullUp &
        (portDir | ~pin_output_value_bit)) == '0) else $error("pull-up");
    a_sleep_hold: assert property ((live_r[3] &&
        opCond == PPS_COND_SLEEP && mcuMode == 2'h3)[*2] |->
        $stable(pinOut[23:0]) && $stable(pinOe[23:0])) else $error("hold");
    a_periph_take: assert property (live_r[3] &&
        opCond == PPS_COND_NORMAL |=> pinOe[39:32] == $past(periphEn[39:32]
        & periphOe[39:32] | ~periphEn[39:32] & portDir[39:32]))
        else $error("port dir");
    a_clock_run: assert property ((live_r[3] &&
        opCond == PPS_COND_NORMAL && mcuMode == 2'h3 && portDir[30])[*2]
        |-> pinOe[30] && pinOut[30] == sysClkOut) else $error("clk out");
    a_clock_high: assert property ((live_r[3] &&
        opCond == PPS_COND_SWSTBY && mcuMode == 2'h3)[*2] |->
        pinOe[30] == portDir[30] && (pinOut[30] || !portDir[30]))
        else $error("clk standby");
    a_addr_out: assert property (live_r[3] &&
        opCond == PPS_COND_NORMAL && mcuMode == 2'h2 |=> pinOe[15:0] ==
        $past(portDir[15:0]) && (pinOut[15:0] & pinOe[15:0]) ==
        ($past(busAddr) & pinOe[15:0])) else $error("addr");
    a_exp_reset: assert property (live_r[3] &&
        opCond == PPS_COND_RESET && mcuMode == 2'h1 |=> pinOe[23:0] ==
        24'h00FFFF && pinOut[15:0] == 16'h0 && pinOut[54:52] == 3'h7)
        else $error("reset pins");
    a_sleep_addr: assert property ((live_r[3] &&
        opCond == PPS_COND_SLEEP && mcuMode == 2'h1)[*2] |->
        $stable(pinOut[15:0]) && pinOut[54:52] == 3'h7 && pinOe[23:16]
        == 8'h0 && pinOut[30] == sysClkOut) else $error("sleep pins");
    c_hw: cover property (live_r[3] && opCond == PPS_COND_HWSTBY);
    c_m1: cover property (opCond == PPS_COND_RESET && mcuMode == 2'h1);
    c_m3: cover property (opCond == PPS_COND_SWSTBY && mcuMode == 2'h3);
endmodule : pps_port_pin_state_asserts

bind pps_port_pin_state pps_port_pin_state_asserts #(.NPORT(NPORT)) chk (.*);

/* pps_board_model.sv */
module pps_board_model #(parameter int NPORT = 7) (
    // device pins
    input  wire logic                clk_sys,
    input  wire logic [NPORT*8-1:0]  pinOut, pinOe, pinPullUp,
    // level seen on the board
    output logic [NPORT*8-1:0]       pinLevel
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [NPORT*8-1:0] drift = '0;
    // a floating pin keeps changing so stale data never looks driven
    always @(posedge clk_sys) drift <= ~drift;
    assign pinLevel = pinOe & pinOut | ~pinOe & (pinPullUp | drift);
endmodule : pps_board_model

/* pps_port_pin_state_tb_top.sv */
module pps_port_pin_state_tb_top
    import pps_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys, reset_n, busWrEn, busWrStrobe, busRdStrobe;
    logic addr_strobe_pin, sysClkOut, peripheralReset;
    pps_cond_e opCond;
    logic [1:0] mcuMode;
    logic [15:0] busAddr, lastA;
    logic [7:0] busWrData;
    logic [55:0] portDir, pin_output_value_bit, periphEn, periphOe;
    logic [55:0] periphOut, pinOut, pinOe, pinPullUp, pinLevel;
    logic [31:0] seed = 32'h489F9828;
    int num_errors = 0;
    int compares = 0;
    pps_cond_e seq [5] = '{PPS_COND_RESET, PPS_COND_NORMAL,
        PPS_COND_SLEEP, PPS_COND_SWSTBY, PPS_COND_HWSTBY};
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin \
    num_errors++; $display("mismatch %0t %s", $time, m); end end
    pps_port_pin_state #(.NPORT(7)) dut (.*);
    pps_board_model board (.*);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [55:0] r56();
        return 56'({rnd(), rnd()});
    endfunction : r56
    function automatic logic [7:0] expOe(int p);
        return periphEn[p*8+:8] & periphOe[p*8+:8] |
            ~periphEn[p*8+:8] & portDir[p*8+:8];
    endfunction : expOe
    function automatic logic [7:0] expHeldPu(int p);
        return ~portDir[p*8+:8] & pin_output_value_bit[p*8+:8];
    endfunction : expHeldPu
    // a pin that nothing drives gets its pull-up only if its direction bit is 0 and its value bit is 1
    function automatic logic [7:0] expPu(int p);
        return expHeldPu(p) & ~expOe(p);
    endfunction : expPu
    task automatic tally_and_finish();
        if (num_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic phase(int r, int m, pps_cond_e c);
        @(posedge clk_sys);
        #1;
        lastA = busAddr;
        opCond = c;
        mcuMode = 2'(m);
        portDir = r == 0 ? '1 : r == 1 ? '0 : r56();
        pin_output_value_bit = r == 0 ? '0 : r == 1 ? '1 : r56();
        // no peripheral on the bus ports, the clock pin or the strobes
        periphEn = r56() & 56'h8FFFFFBF000000;
        periphOe = r56();
        periphOut = r56();
        {busAddr, busWrData, busWrEn, addr_strobe_pin, busWrStrobe,
            busRdStrobe} = 28'(rnd());
        repeat (3) @(posedge clk_sys);
        #1;
        if (c == PPS_COND_HWSTBY) `CHK(pinOe, 56'h0, "hw")
        if (c == PPS_COND_NORMAL) begin
            `CHK(pinOe[39:32], expOe(4), "p5")
            `CHK(pinPullUp[47:40], expPu(5), "pu")
            `CHK(peripheralReset, 1'b0, "pn")
        end
        if (c == PPS_COND_SWSTBY) begin
            `CHK(peripheralReset, 1'b1, "pr")
            `CHK(pinOe[29:24], portDir[29:24], "p4")
            `CHK(pinPullUp[47:40], expHeldPu(5), "ps")
        end
        if (m == 3 && c == PPS_COND_NORMAL) begin
            `CHK(pinOe[30], portDir[30], "ck")
            `CHK(pinLevel[30] | ~portDir[30], sysClkOut | ~portDir[30], "ck")
        end
        if (m == 3 && c == PPS_COND_SWSTBY) begin
            `CHK(pinOe[30], portDir[30], "cs")
            `CHK(pinLevel[30] | ~portDir[30], 1'b1, "cs")
        end
        if (m == 1 && c == PPS_COND_RESET) begin
            `CHK(pinOe[23:0], 24'h00FFFF, "m1")
            `CHK(pinLevel[15:0], 16'h0, "m1")
        end
        if (m == 2 && c == PPS_COND_RESET) begin
            `CHK(pinOe[15:0], 16'h0, "m2")
        end
        if (m == 1 && c == PPS_COND_SLEEP) begin
            `CHK(pinLevel[15:0], lastA, "sl")
        end
    endtask : phase
    initial begin
        clk_sys = 0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(negedge clk_sys) sysClkOut <= ~sysClkOut;
    initial begin
        reset_n = 0;
        sysClkOut = 0;
        opCond = PPS_COND_RESET;
        {mcuMode, portDir, pin_output_value_bit, periphEn} = '0;
        {periphOe, periphOut, busAddr, busWrData, busWrEn} = '0;
        {addr_strobe_pin, busWrStrobe, busRdStrobe} = 3'h7;
        repeat (20) @(posedge clk_sys);
        #1;
        reset_n = 1;
        repeat (4) @(posedge clk_sys);
        for (int r = 0; r < 3; r++)
            for (int m = 1; m < 4; m++)
                foreach (seq[i]) phase(r, m, seq[i]);
        tally_and_finish();
    end
    initial begin
        #20000;
        num_errors++;
        tally_and_finish();
    end
endmodule : pps_port_pin_state_tb_top
